// ---- rtl/ldr_dist_ram.sv ----
/*
 * Lookup-table distributed memory: sixteen-entry sections cascaded to
 * DEPTH entries by WIDTH bits, optional second read-only port, optional
 * registered read outputs.
 * Assumes: user logic drives address, data and strobe synchronous to
 * clk_sys and holds the strobe for the edge it wants to write on.
 */
`timescale 1ns/1ps

module ldr_dist_ram #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 1,
    parameter bit DUAL_PORT = 1'b1,
    parameter bit WE_INVERT = 1'b0,
    parameter ldr_pkg::ldr_slice_t SLICE_KIND = ldr_pkg::MEMORY_CAPABLE_SLICE,
    parameter logic [DEPTH*WIDTH-1:0] INIT_BITS = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // write and primary read port
    input wire ldr_pkg::ldr_wr_t writeReq,
    input wire logic [WIDTH-1:0] writeData,
    // secondary read-only port
    input wire logic [ldr_pkg::ADDR_MAX_W-1:0] secondary_read_address,
    // output register enable
    input wire logic outCaptureEn,
    // combinational read outputs
    output logic [WIDTH-1:0] primary_read_out,
    output logic [WIDTH-1:0] secondary_read_out,
    // registered read outputs
    output logic [WIDTH-1:0] primaryReadOutReg,
    output logic [WIDTH-1:0] secondaryReadOutReg,
    // logic blocks taken by this shape
    output logic [ldr_pkg::BLOCK_CNT_W-1:0] blocksUsed
);
    import ldr_pkg::*;

    // ------------------------------------------------------------
    // shape arithmetic
    // ------------------------------------------------------------

    // cascaded shapes are built from whole sections; depth past the
    // documented maximum is clamped rather than silently wrapping
    // depth limit
    localparam int DEPTH_USED = (DEPTH > DEPTH_MAX) ? DEPTH_MAX : DEPTH;
    localparam int SECTIONS = (DEPTH_USED + LUT_DEPTH - 1) / LUT_DEPTH;
    localparam int ADDR_W = (SECTIONS > 2) ? ADDR_MAX_W :
                            (SECTIONS > 1) ? LUT_ADDR_W + 1 : LUT_ADDR_W;
    localparam int SEL_W = (ADDR_W > LUT_ADDR_W) ? ADDR_W - LUT_ADDR_W : 1;

    // a dual-port bit costs two tables, halving the block capacity
    // block capacity
    localparam int BITS_PER_BLOCK = DUAL_PORT ? DP_BITS_PER_BLOCK : SP_BITS_PER_BLOCK;
    localparam int TOTAL_BITS = SECTIONS * LUT_DEPTH * WIDTH;
    localparam int BLOCKS = (TOTAL_BITS + BITS_PER_BLOCK - 1) / BITS_PER_BLOCK;
    localparam logic [BLOCK_CNT_W-1:0] BLOCKS_VAL = BLOCKS[BLOCK_CNT_W-1:0];

    localparam bit CAN_STORE = (SLICE_KIND == MEMORY_CAPABLE_SLICE);

    // ------------------------------------------------------------
    // write strobe handling
    // ------------------------------------------------------------
    wire strobeRaw;
    wire strobeActive;
    wire writeAllowed;

    assign strobeRaw = writeReq.writeStrobe;
    assign strobeActive = WE_INVERT ? ~strobeRaw : strobeRaw;
    // a logic-only slice behaves as a rom: the strobe is dropped here
    // strobe gates store
    assign writeAllowed = strobeActive & CAN_STORE;

    // ------------------------------------------------------------
    // address split
    // ------------------------------------------------------------
    wire [LUT_ADDR_W-1:0] priLow;
    wire [LUT_ADDR_W-1:0] secLow;
    wire [SEL_W-1:0] priSel;
    wire [SEL_W-1:0] secSel;

    assign priLow = writeReq.addr[LUT_ADDR_W-1:0];
    assign secLow = secondary_read_address[LUT_ADDR_W-1:0];

    // a single section has no upper bits to look at
    generate
        if (ADDR_W > LUT_ADDR_W) begin : g_upper
            assign priSel = writeReq.addr[ADDR_W-1:LUT_ADDR_W];
            assign secSel = secondary_read_address[ADDR_W-1:LUT_ADDR_W];
        end else begin : g_noupper
            assign priSel = '0;
            assign secSel = '0;
        end
    endgenerate

    // ------------------------------------------------------------
    // section write enables
    // ------------------------------------------------------------
    wire [SECTIONS-1:0] sectionWe;

    // only the addressed section sees the strobe; all others hold
    // unselected unchanged
    generate
        for (genvar s = 0; s < SECTIONS; s++) begin : g_we
            assign sectionWe[s] = writeAllowed & (priSel == SEL_W'(s));
        end
    endgenerate

    // ------------------------------------------------------------
    // table array
    // ------------------------------------------------------------
    wire [SECTIONS-1:0] priBits [WIDTH];
    wire [SECTIONS-1:0] secBits [WIDTH];

    // one table per section per bit, plus a shadow copy for the
    // second port; the shadow has its own read address but shares
    // the write path so both copies never disagree
    // cascade sections
    generate
        for (genvar w = 0; w < WIDTH; w++) begin : g_bit
            for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
                localparam int INIT_LSB = w * DEPTH_USED + s * LUT_DEPTH;
                localparam int INIT_TOP = INIT_LSB + LUT_DEPTH;
                localparam logic [LUT_DEPTH-1:0] CELL_INIT =
                    (INIT_TOP <= DEPTH * WIDTH) ? INIT_BITS[INIT_LSB +: LUT_DEPTH]
                                                : LUT_INIT_ZERO;

                ldr_lut_cell #(
                    .INIT(CELL_INIT)
                ) u_pri (
                    .clk_sys(clk_sys),
                    .rst_n(rst_n),
                    .writeEn(sectionWe[s]),
                    .writeAddr(priLow),
                    .writeBit(writeData[w]),
                    .readAddr(priLow),
                    .readBit(priBits[w][s])
                );

                if (DUAL_PORT) begin : g_dp
                    ldr_lut_cell #(
                        .INIT(CELL_INIT)
                    ) u_sec (
                        .clk_sys(clk_sys),
                        .rst_n(rst_n),
                        .writeEn(sectionWe[s]),
                        .writeAddr(priLow),
                        .writeBit(writeData[w]),
                        .readAddr(secLow),
                        .readBit(secBits[w][s])
                    );
                end else begin : g_sp
                    assign secBits[w][s] = 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read multiplexers
    // ------------------------------------------------------------
    wire [WIDTH-1:0] priRead;
    wire [WIDTH-1:0] secRead;

    // the section select plays the part of the wide-function muxes;
    // the two ports have separate muxes so neither loads the other
    // ports independent
    generate
        for (genvar w = 0; w < WIDTH; w++) begin : g_mux
            assign priRead[w] = priBits[w][priSel];
            assign secRead[w] = DUAL_PORT ? secBits[w][secSel] : 1'b0;
        end
    endgenerate

    assign primary_read_out = priRead;
    assign secondary_read_out = secRead;

    // ------------------------------------------------------------
    // optional synchronous read path
    // ------------------------------------------------------------

    // the capture enable is separate from the write strobe, so the
    // user may freeze the registered value while writing continues
    // registered read
    ldr_out_reg #(
        .WIDTH(WIDTH)
    ) u_pri_reg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .captureEn(outCaptureEn),
        .dataIn(priRead),
        .dataOut(primaryReadOutReg)
    );

    ldr_out_reg #(
        .WIDTH(WIDTH)
    ) u_sec_reg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .captureEn(outCaptureEn),
        .dataIn(secRead),
        .dataOut(secondaryReadOutReg)
    );

    // ------------------------------------------------------------
    // capacity report
    // ------------------------------------------------------------
    logic [BLOCK_CNT_W-1:0] blocks_reg;

    // constant after reset; lets the integrator check the footprint
    // blocks used
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blocks_reg <= BLOCKS_VAL;
        end else begin
            blocks_reg <= BLOCKS_VAL;
        end
    end

    assign blocksUsed = blocks_reg;

endmodule : ldr_dist_ram

// ---- rtl/ldr_lut_cell.sv ----
/*
 * One sixteen-entry by one-bit lookup-table memory: clocked write,
 * combinational read on its own read address.
 * Assumes: write strobe already polarity-corrected and section-decoded.
 */
`timescale 1ns/1ps

module ldr_lut_cell #(
    parameter logic [ldr_pkg::LUT_DEPTH-1:0] INIT = ldr_pkg::LUT_INIT_ZERO
) (
    // clock and preload
    input wire logic clk_sys,
    input wire logic rst_n,
    // write side
    input wire logic writeEn,
    input wire logic [ldr_pkg::LUT_ADDR_W-1:0] writeAddr,
    input wire logic writeBit,
    // read side
    input wire logic [ldr_pkg::LUT_ADDR_W-1:0] readAddr,
    output logic readBit
);
    import ldr_pkg::*;

    logic [LUT_DEPTH-1:0] store_reg;

    // reset stands in for configuration preload of the contents
    // preload or zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            store_reg <= INIT;
        end else if (writeEn) begin
            store_reg[writeAddr] <= writeBit;
        end
    end

    // no clock on the read path, so a write shows right after its edge
    // combinational read
    assign readBit = store_reg[readAddr];

endmodule : ldr_lut_cell

// ---- rtl/ldr_out_reg.sv ----
/*
 * Optional capture flops behind the read outputs.
 * Assumes: same clock as the array writes; enable independent of writes.
 */
`timescale 1ns/1ps

module ldr_out_reg #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // capture
    input wire logic captureEn,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    import ldr_pkg::*;

    logic [WIDTH-1:0] hold_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
        end else if (captureEn) begin
            hold_reg <= dataIn;
        end
    end

    assign dataOut = hold_reg;

endmodule : ldr_out_reg

// ---- rtl/ldr_pkg.sv ----
/*
 * Shared constants and carrier types for the lookup-table memory block:
 * section geometry, per-block capacity limits, slice kinds, write request.
 * Assumes: included before every ldr_* module; no registers reach software.
 */
package ldr_pkg;

    // ------------------------------------------------------------
    // section geometry
    // ------------------------------------------------------------
    localparam int LUT_DEPTH = 16;             // entries in one lookup table
    localparam int LUT_ADDR_W = 4;             // address bits of one table
    localparam int ADDR_MAX_W = 6;             // widest address of the block
    localparam int DEPTH_MAX = 64;             // deepest shape in one block
    localparam logic [LUT_DEPTH-1:0] LUT_INIT_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // storage capacity of one logic block, in bits
    // ------------------------------------------------------------
    localparam int SP_BITS_PER_BLOCK = 64;
    localparam int DP_BITS_PER_BLOCK = 32;
    localparam int BLOCK_CNT_W = 8;

    // ------------------------------------------------------------
    // slice kinds, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MEMORY_CAPABLE_SLICE = 2'h1,
        LOGIC_ONLY_SLICE = 2'h2
    } ldr_slice_t;

    // ------------------------------------------------------------
    // write request carried from the user logic
    // ------------------------------------------------------------
    typedef struct packed {
        logic writeStrobe;
        logic [ADDR_MAX_W-1:0] addr;
    } ldr_wr_t;

endpackage : ldr_pkg

// ---- verif/ldr_dist_ram_asserts.sv ----
/*
 * Checker for the lookup-table memory top: write landing, copy update,
 * hold on idle edges, output capture and block count.
 * Assumes: strobe active high, bound to every ldr_dist_ram instance.
 */
`timescale 1ns/1ps

module ldr_dist_ram_asserts #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 1,
    parameter bit DUAL_PORT = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // requests
    input wire ldr_pkg::ldr_wr_t writeReq,
    input wire logic [WIDTH-1:0] writeData,
    input wire logic [ldr_pkg::ADDR_MAX_W-1:0] secondary_read_address,
    input wire logic outCaptureEn,
    // outputs
    input wire logic [WIDTH-1:0] primary_read_out,
    input wire logic [WIDTH-1:0] secondary_read_out,
    input wire logic [WIDTH-1:0] primaryReadOutReg,
    input wire logic [WIDTH-1:0] secondaryReadOutReg,
    input wire logic [ldr_pkg::BLOCK_CNT_W-1:0] blocksUsed
);
    import ldr_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int PER = DUAL_PORT ? DP_BITS_PER_BLOCK : SP_BITS_PER_BLOCK;
    localparam int BLK = (((DEPTH + 15) / 16) * 16 * WIDTH + PER - 1) / PER;
    // only the decoded address bits matter, upper bits are ignored
    wire logic [AW-1:0] wAddr = writeReq.addr[AW-1:0];
    wire logic [AW-1:0] sAddr = secondary_read_address[AW-1:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_write_lands: assert property (
        writeReq.writeStrobe ##1 $stable(wAddr) |-> primary_read_out == $past(writeData))
        else $error("primary read misses stored data");
    a_copy_update: assert property (
        writeReq.writeStrobe ##1 (sAddr == $past(wAddr))
        |-> secondary_read_out == $past(writeData))
        else $error("secondary copy not updated");
    a_idle_hold: assert property (
        !writeReq.writeStrobe ##1 $stable(wAddr) |-> $stable(primary_read_out))
        else $error("contents changed without strobe");
    a_second_hold: assert property (
        !writeReq.writeStrobe ##1 $stable(sAddr) |-> $stable(secondary_read_out))
        else $error("secondary output disturbed");
    a_preg_capture: assert property (
        outCaptureEn |=> primaryReadOutReg == $past(primary_read_out))
        else $error("primary register capture wrong");
    a_sreg_capture: assert property (
        outCaptureEn |=> secondaryReadOutReg == $past(secondary_read_out))
        else $error("secondary register capture wrong");
    a_reg_hold: assert property (
        !outCaptureEn |=> $stable(primaryReadOutReg) && $stable(secondaryReadOutReg))
        else $error("output register moved without enable");
    a_block_count: assert property (
        blocksUsed == BLOCK_CNT_W'(BLK))
        else $error("block count wrong");
endmodule : ldr_dist_ram_asserts

bind ldr_dist_ram ldr_dist_ram_asserts #(
    .DEPTH(DEPTH), .WIDTH(WIDTH), .DUAL_PORT(DUAL_PORT)
) chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .writeReq(writeReq), .writeData(writeData),
    .secondary_read_address(secondary_read_address), .outCaptureEn(outCaptureEn),
    .primary_read_out(primary_read_out), .secondary_read_out(secondary_read_out),
    .primaryReadOutReg(primaryReadOutReg), .secondaryReadOutReg(secondaryReadOutReg),
    .blocksUsed(blocksUsed)
);

// ---- verif/ldr_dist_ram_tb.sv ----
/*
 * Self-checking bench: array model with preload, compared every cycle.
 * Assumes: 32 x 2 dual-port shape, strobe active high.
 */
`timescale 1ns/1ps

`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, act, exp); end end

module ldr_dist_ram_tb;
    import ldr_pkg::*;
    localparam int DEPTH = 32;
    localparam int WIDTH = 2;
    localparam logic [63:0] INIT = 64'hA5C3_0F96_3C5A_E117;
    // footprint of whole sections over the dual-port block capacity
    localparam int BLK_EXP = ((DEPTH + LUT_DEPTH - 1) / LUT_DEPTH * LUT_DEPTH * WIDTH
                              + DP_BITS_PER_BLOCK - 1) / DP_BITS_PER_BLOCK;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    ldr_wr_t writeReq;
    logic [1:0] writeData, pOut, sOut, pReg, sReg, expP, expS;
    logic [5:0] secAddr, a;
    logic capEn;
    logic [7:0] blocksUsed;
    logic [1:0] mem [DEPTH];
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    ldr_user_drv #(.WIDTH(WIDTH)) drv_u (.clk_sys(clk_sys), .writeReq(writeReq),
        .writeData(writeData), .secAddr(secAddr), .capEn(capEn));

    ldr_dist_ram #(.DEPTH(DEPTH), .WIDTH(WIDTH), .DUAL_PORT(1'b1), .WE_INVERT(1'b0),
        .SLICE_KIND(MEMORY_CAPABLE_SLICE), .INIT_BITS(INIT)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .writeReq(writeReq), .writeData(writeData),
        .secondary_read_address(secAddr), .outCaptureEn(capEn),
        .primary_read_out(pOut), .secondary_read_out(sOut),
        .primaryReadOutReg(pReg), .secondaryReadOutReg(sReg), .blocksUsed(blocksUsed));

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic preload();
        for (int i = 0; i < DEPTH * WIDTH; i++) mem[i % DEPTH][i / DEPTH] = INIT[i];
        expP = '0;
        expS = '0;
    endtask : preload

    // one cycle: drive, compare before the edge, then advance the model
    task automatic step(input logic s, input logic [5:0] ad, input logic [1:0] d,
                        input logic [5:0] sa, input logic c);
        logic [1:0] oldP;
        logic [1:0] oldS;
        drv_u.put(s, ad, d, sa, c);
        #1;
        oldP = mem[ad[4:0]];
        oldS = mem[sa[4:0]];
        `CHK(pOut, oldP)
        `CHK(sOut, oldS)
        `CHK(pReg, expP)
        `CHK(sReg, expS)
        `CHK(blocksUsed, 8'(BLK_EXP))
        if (c) begin
            expP = oldP;
            expS = oldS;
        end
        if (s) mem[ad[4:0]] = d;
    endtask : step

    // hang guard, the run needs well under 1000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        void'($urandom(34));
        preload();
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        // preload read through both section muxes
        for (int i = 0; i < DEPTH; i++) step(1'b0, 6'(i), 2'h0, 6'(31 - i), 1'b1);
        for (int i = 0; i < 64; i++) step(1'b1, 6'(i), 2'($urandom), 6'($urandom), 1'b1);
        a = '0;
        for (int i = 0; i < 300; i++) begin
            if ($urandom % 2) a = 6'($urandom);
            step(1'(($urandom)), a, 2'($urandom), ($urandom % 2) ? a : 6'($urandom),
                 1'($urandom));
        end
        // mid-run reset brings the preload back
        @(negedge clk_sys) rst_n = 1'b0;
        preload();
        for (int i = 0; i < 3; i++) step(1'b0, 6'(i), 2'h0, 6'(i + 7), 1'b0);
        @(negedge clk_sys) rst_n = 1'b1;
        for (int i = 0; i < DEPTH; i++) step(1'b0, 6'(i), 2'h0, 6'(i ^ 5), 1'b1);
        close_out();
    end
endmodule : ldr_dist_ram_tb

// ---- verif/ldr_user_drv.sv ----
/*
 * User-logic model driving address, data, strobe and capture enable.
 * Assumes: memory samples on the rising edge of clk_sys.
 */
`timescale 1ns/1ps

module ldr_user_drv #(
    parameter int WIDTH = 2
) (
    // clock
    input wire logic clk_sys,
    // request toward the memory
    output ldr_pkg::ldr_wr_t writeReq,
    output logic [WIDTH-1:0] writeData,
    output logic [5:0] secAddr,
    output logic capEn
);
    import ldr_pkg::*;
    // quiet request from time zero
    initial begin
        writeReq = '0;
        writeData = '0;
        secAddr = '0;
        capEn = 1'b0;
    end
    // strobe held over edge
    // change only at the falling edge so every field is stable at the rise
    task automatic put(input logic s, input logic [5:0] a, input logic [WIDTH-1:0] d,
                       input logic [5:0] sa, input logic c);
        @(negedge clk_sys);
        writeReq.writeStrobe = s;
        writeReq.addr = a;
        writeData = d;
        secAddr = sa;
        capEn = c;
    endtask : put
endmodule : ldr_user_drv
